// ==== src/dpms_map.svh ====
// register map, timing counts and field positions of the mailbox/semaphore port controller
//
// Contract
// RL1: top word is the right port's mailbox (fff or 1fff).
// RL2: word one below the top is the left port's mailbox.
// RL3: writing the other port's mailbox raises that port's mailbox flag.
// RL4: owner reading its own mailbox clears its flag.
// RL5: reading the other mailbox returns data, flag untouched.
// RL6: busy toward a port blocks its mailbox write from setting the flag.
// RL7: busy toward a port blocks its own mailbox read from clearing the flag.
// RL8: address contention grants the word to exactly one port.
// RL9: master busy asserts a set delay after match or select.
// RL10: master/slave strap makes busy an output or an input.
// RL11: writers to a slave wait until busy has settled before strobing.
// RL12: eight shared token latches, apart from the memory array.
// RL13: token select low picks a latch with address bits 0 to 2.
// RL14: memory select stays high whenever the token select is low.
// RL15: a token write uses data bit 0 only.
// RL16: writing zero to a free token: writer reads 0, other reads 1.
// RL17: owner writing one with no request frees the token.
// RL18: a pending request takes the token as soon as the owner releases.
// RL19: token read drives every data line, held in an output register.
// RL20: simultaneous token access grants one side only.
// RL21: after a token write, selects stay off a gap before readback.
// RL22: write strobe low writes the byte lanes whose selects are low.
// RL23: read drives only selected lanes, floats otherwise; the model drives unselected lanes with the inverse of the last value.
// RL24: never memory select with token select while a byte select is low.
// RL25: busy inhibits the losing port's write to the contended word.
`ifndef DPMS_MAP_SVH
`define DPMS_MAP_SVH
`define DPMS_OFF_CMD 12'h000
`define DPMS_OFF_ADDR 12'h004
`define DPMS_OFF_WDATA 12'h008
`define DPMS_OFF_RDATA 12'h00c
`define DPMS_OFF_STATUS 12'h010
`define DPMS_CMD_OP_LSB 0
`define DPMS_CMD_HB_BIT 2
`define DPMS_CMD_LB_BIT 3
`define DPMS_ST_ACTIVE 0
`define DPMS_ST_MBOX 1
`define DPMS_ST_CONT 2
`define DPMS_ST_OWNED 3
`define DPMS_ST_REFUSED 4
`define DPMS_ST_DONE 5
`define DPMS_RIGHT_MBOX_4K 13'h0fff
`define DPMS_LEFT_MBOX_4K 13'h0ffe
`define DPMS_RIGHT_MBOX_8K 13'h1fff
`define DPMS_LEFT_MBOX_8K 13'h1ffe
`define DPMS_TOKEN_ADDR_BITS 3
`define DPMS_CLK_PERIOD_NS 4
`define DPMS_SETTLE_NS 20
`define DPMS_PULSE_NS 40
`define DPMS_GAP_NS 20
`define DPMS_CYC(ns) (((ns) + `DPMS_CLK_PERIOD_NS - 1) / `DPMS_CLK_PERIOD_NS)
`define DPMS_SETTLE_CYC `DPMS_CYC(`DPMS_SETTLE_NS)
`define DPMS_PULSE_CYC `DPMS_CYC(`DPMS_PULSE_NS)
`define DPMS_GAP_CYC `DPMS_CYC(`DPMS_GAP_NS)
`define DPMS_RESET_DATA 32'h0000_0000
`endif

// ==== src/dpms_pkg.sv ====
// types shared by the mailbox/semaphore port controller
package dpms_pkg;
  typedef enum logic [1:0] {
    DPMS_OP_MEM_RD,
    DPMS_OP_MEM_WR,
    DPMS_OP_TOK_RD,
    DPMS_OP_TOK_WR
  } dpms_op_t;

  typedef enum {DPMS_IDLE, DPMS_SETUP, DPMS_STROBE, DPMS_GAP} dpms_state_t;

  typedef struct packed {
    dpms_op_t op;
    logic hb_en;
    logic lb_en;
  } dpms_cmd_t;

  typedef struct packed {
    logic [12:0] addr;
    logic port_sel_n;
    logic write_strobe_n;
    logic output_enable_n;
    logic high_byte_select_n;
    logic low_byte_select_n;
    logic token_latch_select_n;
  } dpms_pins_t;
endpackage : dpms_pkg

// ==== src/dpms_host.sv ====
// apb-controlled host that drives one port of the dual-port memory with mailbox and tokens
`timescale 1ns/1ns
`include "dpms_map.svh"
module dpms_host
  import dpms_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [12:0] mem_addr_out,
  output logic port_sel_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out,
  output logic high_byte_select_n_out,
  output logic low_byte_select_n_out,
  output logic token_latch_select_n_out,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n_out,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic contention_n_in,
  input wire logic mailbox_flag_n_in
);
  localparam logic [7:0] SETTLE_CYC = 8'(`DPMS_SETTLE_CYC);
  localparam logic [7:0] PULSE_CYC = 8'(`DPMS_PULSE_CYC);
  localparam logic [7:0] GAP_CYC = 8'(`DPMS_GAP_CYC);

  function automatic logic is_token(input dpms_op_t op);
    return op == DPMS_OP_TOK_RD || op == DPMS_OP_TOK_WR;
  endfunction : is_token

  function automatic logic is_write(input dpms_op_t op);
    return op == DPMS_OP_MEM_WR || op == DPMS_OP_TOK_WR;
  endfunction : is_write

  dpms_state_t state_reg;
  dpms_cmd_t cmd_reg;
  dpms_pins_t pins_reg;
  logic [12:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [7:0] cnt_reg;
  logic owned_reg;
  logic refused_reg;
  logic done_reg;
  logic drive_reg;
  logic [DATA_W-1:0] data_meta_reg;
  logic [DATA_W-1:0] data_sync_reg;
  logic [1:0] cont_meta_reg;
  logic [1:0] cont_sync_reg;
  logic contention_sync;
  logic mailbox_sync;

  // pins from the other chip pass two flops before anything looks at them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_meta_reg <= '0;
      data_sync_reg <= '0;
      cont_meta_reg <= 2'h3;
      cont_sync_reg <= 2'h3;
    end else begin
      data_meta_reg <= data_in;
      data_sync_reg <= data_meta_reg;
      cont_meta_reg <= {mailbox_flag_n_in, contention_n_in};
      cont_sync_reg <= cont_meta_reg;
    end
  end
  assign contention_sync = !cont_sync_reg[0];
  assign mailbox_sync = !cont_sync_reg[1];

  logic wr_acc;
  logic cmd_go;
  logic cmd_ok;
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign cmd_go = wr_acc && paddr_in == `DPMS_OFF_CMD && state_reg == DPMS_IDLE;

  always_comb begin
    cmd_ok = 1'b1;
    unique case (paddr_in)
      `DPMS_OFF_CMD, `DPMS_OFF_ADDR, `DPMS_OFF_WDATA, `DPMS_OFF_STATUS: cmd_ok = 1'b1;
      `DPMS_OFF_RDATA: cmd_ok = !pwrite_in;
      default: cmd_ok = 1'b0;
    endcase
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready_out = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && !cmd_ok;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= `DPMS_RESET_DATA;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        `DPMS_OFF_ADDR: prdata_out <= {19'h0, addr_reg};
        `DPMS_OFF_WDATA: prdata_out <= 32'(wdata_reg);
        `DPMS_OFF_RDATA: prdata_out <= 32'(rdata_reg);
        `DPMS_OFF_STATUS: prdata_out <= {26'h0, done_reg, refused_reg, owned_reg,
                                         contention_sync, mailbox_sync,
                                         state_reg != DPMS_IDLE};
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // address and write data refuse changes while a transfer is on the pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      cmd_reg <= '0;
    end else if (wr_acc && state_reg == DPMS_IDLE) begin
      if (paddr_in == `DPMS_OFF_ADDR) addr_reg <= pwdata_in[12:0];
      if (paddr_in == `DPMS_OFF_WDATA) wdata_reg <= pwdata_in[DATA_W-1:0];
      if (paddr_in == `DPMS_OFF_CMD) begin
        cmd_reg.op <= dpms_op_t'(pwdata_in[`DPMS_CMD_OP_LSB +: 2]);
        cmd_reg.hb_en <= pwdata_in[`DPMS_CMD_HB_BIT];
        cmd_reg.lb_en <= pwdata_in[`DPMS_CMD_LB_BIT];
      end
    end
  end

  logic setup_end;
  logic strobe_end;
  assign setup_end = state_reg == DPMS_SETUP && cnt_reg == SETTLE_CYC - 8'h01;
  assign strobe_end = state_reg == DPMS_STROBE && cnt_reg == PULSE_CYC - 8'h01;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= DPMS_IDLE;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      unique case (state_reg)
        DPMS_IDLE: begin
          cnt_reg <= '0;
          if (cmd_go) state_reg <= DPMS_SETUP;
        end
        DPMS_SETUP: if (setup_end) begin
          cnt_reg <= '0;
          // a losing write is dropped, never strobed into the contended word
          if (is_write(cmd_reg.op) && !is_token(cmd_reg.op) && contention_sync)
            state_reg <= DPMS_GAP; // RL11
          else
            state_reg <= DPMS_STROBE;
        end
        DPMS_STROBE: if (strobe_end) begin
          cnt_reg <= '0;
          state_reg <= DPMS_GAP;
        end
        DPMS_GAP: if (cnt_reg == GAP_CYC - 8'h01) state_reg <= DPMS_IDLE; // RL21
      endcase
    end
  end

  // pin levels, all registered so the memory sees clean edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_reg <= '{addr: 13'h0000, default: 1'b1};
      drive_reg <= 1'b0;
    end else begin
      pins_reg <= '{addr: pins_reg.addr, default: 1'b1};
      drive_reg <= 1'b0;
      if ((state_reg == DPMS_IDLE && cmd_go) || state_reg == DPMS_SETUP
          || (state_reg == DPMS_STROBE && !strobe_end)) begin
        if (is_token(cmd_reg.op) || (state_reg == DPMS_IDLE && pwdata_in[1])) begin
          // token access: memory select and byte selects stay high
          pins_reg.addr <= {10'h000, addr_reg[`DPMS_TOKEN_ADDR_BITS-1:0]}; // RL13
          pins_reg.token_latch_select_n <= 1'b0; // RL14 RL24
        end else begin
          pins_reg.addr <= addr_reg;
          pins_reg.port_sel_n <= 1'b0;
          pins_reg.high_byte_select_n <= !cmd_reg.hb_en; // RL22 RL23
          pins_reg.low_byte_select_n <= !cmd_reg.lb_en;
        end
        if (state_reg == DPMS_IDLE) begin
          pins_reg.port_sel_n <= pwdata_in[1];
          pins_reg.high_byte_select_n <= pwdata_in[1] || !pwdata_in[`DPMS_CMD_HB_BIT];
          pins_reg.low_byte_select_n <= pwdata_in[1] || !pwdata_in[`DPMS_CMD_LB_BIT];
          pins_reg.token_latch_select_n <= !pwdata_in[1];
          pins_reg.addr <= pwdata_in[1] ? {10'h000, addr_reg[2:0]} : addr_reg;
        end else begin
          drive_reg <= is_write(cmd_reg.op);
        end
        if (setup_end || state_reg == DPMS_STROBE) begin
          pins_reg.write_strobe_n <= !is_write(cmd_reg.op);
          pins_reg.output_enable_n <= is_write(cmd_reg.op);
        end
        if (setup_end && is_write(cmd_reg.op) && !is_token(cmd_reg.op) && contention_sync)
          pins_reg <= '{addr: pins_reg.addr, default: 1'b1}; // RL11
      end
    end
  end

  // token write carries its value in bit 0 only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) data_out <= '0;
    else if (is_token(cmd_reg.op)) data_out <= {{(DATA_W-1){1'b0}}, wdata_reg[0]}; // RL15
    else data_out <= wdata_reg;
  end
  assign data_oe_n_out = !drive_reg;

  // read data taken at the end of the pulse; set wins over the write-one clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= '0;
      owned_reg <= 1'b0;
      refused_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (wr_acc && paddr_in == `DPMS_OFF_STATUS) begin
        if (pwdata_in[`DPMS_ST_REFUSED]) refused_reg <= 1'b0;
        if (pwdata_in[`DPMS_ST_DONE]) done_reg <= 1'b0;
      end
      if (strobe_end && !is_write(cmd_reg.op)) rdata_reg <= data_sync_reg;
      if (strobe_end && cmd_reg.op == DPMS_OP_TOK_RD) owned_reg <= !data_sync_reg[0]; // RL21
      if (setup_end && is_write(cmd_reg.op) && !is_token(cmd_reg.op) && contention_sync)
        refused_reg <= 1'b1;
      if (state_reg == DPMS_GAP && cnt_reg == GAP_CYC - 8'h01) done_reg <= 1'b1;
    end
  end

  assign mem_addr_out = pins_reg.addr;
  assign port_sel_n_out = pins_reg.port_sel_n;
  assign write_strobe_n_out = pins_reg.write_strobe_n;
  assign output_enable_n_out = pins_reg.output_enable_n;
  assign high_byte_select_n_out = pins_reg.high_byte_select_n;
  assign low_byte_select_n_out = pins_reg.low_byte_select_n;
  assign token_latch_select_n_out = pins_reg.token_latch_select_n;

  // helper: cycles since the token select last went high
  logic [7:0] idle_cnt_reg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) idle_cnt_reg <= 8'hff;
    else if (!token_latch_select_n_out) idle_cnt_reg <= '0;
    else if (idle_cnt_reg != 8'hff) idle_cnt_reg <= idle_cnt_reg + 8'h01;
  end

  property p_sel_exclusive;
    @(posedge clk_in) disable iff (!rst_n_in)
      !token_latch_select_n_out |-> port_sel_n_out;
  endproperty
  a_sel_exclusive: assert property (p_sel_exclusive) // RL14
    else $error("memory select low during token access");

  property p_token_bytes_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      !token_latch_select_n_out |-> high_byte_select_n_out && low_byte_select_n_out;
  endproperty
  a_token_bytes_off: assert property (p_token_bytes_off) // RL24
    else $error("byte select low during token access");

  property p_token_addr;
    @(posedge clk_in) disable iff (!rst_n_in)
      !token_latch_select_n_out |-> mem_addr_out[12:3] == 10'h000
        && ($past(token_latch_select_n_out) || $stable(mem_addr_out));
  endproperty
  a_token_addr: assert property (p_token_addr) // RL13
    else $error("token address not confined to low bits");

  property p_write_settled;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(write_strobe_n_out) && !port_sel_n_out |->
        $past(port_sel_n_out, 3) == 1'b0 && $stable(mem_addr_out) && !$past(contention_sync);
  endproperty
  a_write_settled: assert property (p_write_settled) // RL11
    else $error("write strobed before busy settled");

  property p_token_gap;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(token_latch_select_n_out) |-> $past(idle_cnt_reg) >= GAP_CYC;
  endproperty
  a_token_gap: assert property (p_token_gap) // RL21
    else $error("token reselected before the readback gap");

  property p_drive_on_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      !write_strobe_n_out |-> !data_oe_n_out && output_enable_n_out;
  endproperty
  a_drive_on_write: assert property (p_drive_on_write) // RL22
    else $error("write strobe without data drive");
endmodule : dpms_host

// ==== testbench/dpms_dev_model.sv ====
// behavioural model of one port of the dual-port memory with mailbox and tokens
`timescale 1ns/1ns
`include "dpms_map.svh"
module dpms_dev_model (
  input wire logic clk_in,
  input wire logic [12:0] a_in,
  input wire logic sel_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic hb_n_in,
  input wire logic lb_n_in,
  input wire logic tok_n_in,
  input wire logic [15:0] wd_in,
  input wire logic busy_n_in,
  input wire logic post_in,
  input wire logic peer_req_in,
  output logic [15:0] rd_out,
  output logic flag_n_out,
  output logic peer_flag_n_out
);
  logic [15:0] mem [0:8191];
  logic [15:0] last = 16'h0000;
  logic [7:0] mine = 8'h00;
  logic [7:0] other = 8'h00;
  logic [7:0] pend = 8'h00;
  logic tokq = 1'b1;
  logic tok_d = 1'b1;
  logic flag = 1'b0;
  logic peer_flag = 1'b0;
  logic [2:0] t;
  assign t = a_in[2:0];
  assign flag_n_out = ~flag;
  assign peer_flag_n_out = ~peer_flag;
  always @(posedge clk_in) begin
    tok_d <= tok_n_in;
    // latched once per access so a far-side write cannot disturb it
    if (!tok_n_in && tok_d) tokq <= ~mine[t];
    if (!sel_n_in && tok_n_in && !we_n_in) begin
      if (!hb_n_in) mem[a_in][15:8] <= wd_in[15:8];
      if (!lb_n_in) mem[a_in][7:0] <= wd_in[7:0];
      if (busy_n_in && a_in == `DPMS_RIGHT_MBOX_4K) peer_flag <= 1'b1;
    end
    if (!sel_n_in && we_n_in && !oe_n_in && busy_n_in && a_in == `DPMS_LEFT_MBOX_4K) begin
      flag <= 1'b0;
    end else if (post_in) begin
      flag <= 1'b1;
    end
    if (!tok_n_in && sel_n_in && !we_n_in) begin
      if (!wd_in[0]) begin
        if (!other[t]) mine[t] <= 1'b1;
      end else if (mine[t]) begin
        mine[t] <= 1'b0;
        other[t] <= pend[t];
        pend[t] <= 1'b0;
      end
    end
    if (peer_req_in) begin
      // a same-cycle race goes to this port and queues the peer: one owner only
      if (mine[0] || (!tok_n_in && sel_n_in && !we_n_in && !wd_in[0] && t == 3'h0))
        pend[0] <= 1'b1;
      else other[0] <= 1'b1;
    end
    last <= rd_out;
  end
  // released lines show the inverse of the last value, never a stale copy
  always @* begin
    rd_out = ~last;
    if (!tok_n_in && sel_n_in && we_n_in && !oe_n_in) begin
      rd_out = {16{tokq}};
    end else if (!sel_n_in && tok_n_in && we_n_in && !oe_n_in) begin
      if (!hb_n_in) rd_out[15:8] = mem[a_in][15:8];
      if (!lb_n_in) rd_out[7:0] = mem[a_in][7:0];
    end
  end
endmodule : dpms_dev_model

// ==== testbench/test_dualport_mailbox_semaphore.sv ====
// self-checking bench for the apb host driving the mailbox/semaphore memory
`timescale 1ns/1ns
`include "dpms_map.svh"
module test_dualport_mailbox_semaphore;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_out, q, st;
  logic pready_out, pslverr_out, e, busy_n = 1'b1, post = 1'b0, peer_req = 1'b0;
  logic [12:0] mem_addr_out, a;
  logic sel_n, we_n, oe_n, hb_n, lb_n, tok_n, data_oe_n_out, flag_n, peer_flag_n;
  logic [15:0] data_out, dbus, dev_rd, d0, d1;
  logic [1:0] be;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  assign dbus = data_oe_n_out ? dev_rd : data_out;
  initial forever #2 clk_in = ~clk_in;
  dpms_host i_dpms_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .mem_addr_out(mem_addr_out), .port_sel_n_out(sel_n), .write_strobe_n_out(we_n),
    .output_enable_n_out(oe_n), .high_byte_select_n_out(hb_n),
    .low_byte_select_n_out(lb_n), .token_latch_select_n_out(tok_n), .data_out(data_out),
    .data_oe_n_out(data_oe_n_out), .data_in(dbus), .contention_n_in(busy_n),
    .mailbox_flag_n_in(flag_n));
  dpms_dev_model i_dpms_dev_model (.clk_in(clk_in), .a_in(mem_addr_out), .sel_n_in(sel_n),
    .we_n_in(we_n), .oe_n_in(oe_n), .hb_n_in(hb_n), .lb_n_in(lb_n), .tok_n_in(tok_n),
    .wd_in(data_out), .busy_n_in(busy_n), .post_in(post), .peer_req_in(peer_req),
    .rd_out(dev_rd), .flag_n_out(flag_n), .peer_flag_n_out(peer_flag_n));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic chk1(input string n, input logic x, input logic g);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s exp %b got %b", n, x, g);
    end
  endtask : chk1
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // cmd is {low lane, high lane, op}; leaves status in st and rdata in q
  task automatic op(input logic [3:0] c, input logic [12:0] ad, input logic [15:0] d);
    int k;
    apb(1'b1, `DPMS_OFF_ADDR, {19'h0, ad});
    apb(1'b1, `DPMS_OFF_WDATA, {16'h0, d});
    apb(1'b1, `DPMS_OFF_CMD, {28'h0, c});
    k = 0;
    do begin
      apb(1'b0, `DPMS_OFF_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    st = q;
    chk1("op_done", 1'b1, q[`DPMS_ST_DONE]);
    apb(1'b1, `DPMS_OFF_STATUS, 32'h30);
    apb(1'b0, `DPMS_OFF_RDATA, 32'h0);
  endtask : op
  function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic [1:0] b);
    return {b[1] ? n[15:8] : o[15:8], b[0] ? n[7:0] : o[7:0]};
  endfunction : merge
  initial begin
    void'($urandom(95));
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk("idle_pins", 32'h7f, {25'h0, sel_n, we_n, oe_n, hb_n, lb_n, tok_n, data_oe_n_out});
    for (int i = 0; i < 6; i++) begin
      a = 13'($urandom_range(4093, 0));
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      be = 2'($urandom_range(3, 1));
      op(4'hd, a, d0);
      op({be[0], be[1], 2'd1}, a, d1);
      op(4'hc, a, 16'h0);
      chk("mem_rd", {16'h0, merge(d0, d1, be)}, q);
    end
    $display("test mem done");
    op(4'hd, `DPMS_RIGHT_MBOX_4K, 16'hc3c3);
    chk1("peer_flag_set", 1'b0, peer_flag_n);
    op(4'hd, `DPMS_LEFT_MBOX_4K, 16'h5a5a);
    post <= 1'b1;
    @(posedge clk_in);
    post <= 1'b0;
    repeat (4) @(posedge clk_in);
    op(4'hc, `DPMS_RIGHT_MBOX_4K, 16'h0);
    chk1("flag_after_peer_rd", 1'b1, st[1]);
    chk("peer_mbox_rd", 32'hc3c3, q);
    chk1("peer_flag_kept", 1'b0, peer_flag_n);
    // bench stands in for the master's arbitration result on the busy line
    busy_n <= 1'b0;
    op(4'hc, `DPMS_LEFT_MBOX_4K, 16'h0);
    chk1("flag_busy_rd", 1'b1, st[1]);
    op(4'hd, `DPMS_LEFT_MBOX_4K, 16'h1234);
    chk1("wr_refused", 1'b1, st[4]);
    busy_n <= 1'b1;
    op(4'hc, `DPMS_LEFT_MBOX_4K, 16'h0);
    chk1("flag_cleared", 1'b0, st[1]);
    chk("mbox_kept", 32'h5a5a, q);
    $display("test mailbox done");
    for (int i = 0; i < 8; i++) begin
      a = {10'($urandom_range(1023, 0)), 3'(i)};
      op(4'h3, a, 16'($urandom) & 16'hfffe);
      op(4'h2, a, 16'h0);
      chk("tok_own", 32'h0, q);
      chk1("tok_owned", 1'b1, st[3]);
      op(4'h3, a, 16'($urandom) | 16'h0001);
      op(4'h2, a, 16'h0);
      chk("tok_free", 32'hffff, q);
    end
    op(4'h3, 13'h0, 16'h0);
    peer_req <= 1'b1;
    @(posedge clk_in);
    peer_req <= 1'b0;
    op(4'h2, 13'h0, 16'h0);
    chk("tok_held", 32'h0, q);
    op(4'h3, 13'h0, 16'h1);
    op(4'h2, 13'h0, 16'h0);
    chk("tok_passed", 32'hffff, q);
    op(4'h3, 13'h0, 16'h0);
    op(4'h2, 13'h0, 16'h0);
    chk("tok_locked", 32'hffff, q);
    $display("test token done");
    apb(1'b1, 12'h0f0, 32'h1);
    chk1("unmapped_err", 1'b1, e);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped_rd", 32'h0, q);
    apb(1'b1, `DPMS_OFF_RDATA, 32'h1);
    chk1("ro_err", 1'b1, e);
    $display("test apb done");
    print_verdict();
  end
endmodule : test_dualport_mailbox_semaphore
